//--- include/sgec_pkg.sv
// sgec_pkg: register map, field layout and reset values of the status,
// general pin and event counter unit.
// assumes a 12-bit byte address from an avalon-mm slave port.
package sgec_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_ENABLE = 12'h0dc;
  localparam logic [11:0] OFS_PIN    = 12'h0e0;
  localparam logic [11:0] OFS_SEL1   = 12'h0e4;
  localparam logic [11:0] OFS_SEL2   = 12'h0e8;
  localparam logic [11:0] OFS_STATUS = 12'h10c;
  localparam logic [11:0] OFS_CNT1   = 12'h118;
  localparam logic [11:0] OFS_CNT2   = 12'h11c;
  localparam logic [11:0] OFS_THR1   = 12'h120;
  localparam logic [11:0] OFS_THR2   = 12'h124;
  // status bit positions
  localparam int UNIT_LSB  = 7;
  localparam int UNIT_W    = 25;
  localparam int PIN_LSB   = 3;
  localparam int BIT_EC0   = 0;
  localparam int BIT_EC3   = 1;
  localparam int BIT_ECS   = 2;
  // pin control field
  localparam int PF_W      = 8;
  localparam int PF_MODE   = 6;
  localparam int PF_EDGE   = 4;
  localparam int PF_LEVEL  = 4;
  localparam logic [1:0] MODE_IN    = 2'h0;
  localparam logic [1:0] MODE_CONST = 2'h1;
  localparam logic [1:0] MODE_MON   = 2'h3;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_FALL  = 2'h2;
  localparam logic [1:0] EDGE_BOTH  = 2'h3;
  // counter packing: slot 0 is 12 bits wide, slots 1 and 2 are 10 bits
  localparam int CNT_WIDE   = 12;
  localparam int CNT_NARROW = 10;
  localparam int SLOT1_LSB  = 12;
  localparam int SLOT2_LSB  = 22;
  // source select slots of 8 bits: source, enable, clear
  localparam int SEL_SLOT   = 8;
  localparam int SEL_SRC    = 2;
  localparam int SEL_EN     = 1;
  localparam int SEL_CLR    = 0;
  localparam int SEL_USED   = 24;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [11:0] RST_CNT  = 12'h0;
  localparam logic [2:0]  RST_SYNC = 3'h0;
  typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} sgec_bus_t;
endpackage

//--- rtl/sgec_top.sv
// sgec_top: status flags, four general pins and six event counters behind
// an avalon-mm slave with waitrequest.
// assumes unit_event pulses and secondary_status levels on the same clock;
// gpio_in is asynchronous.
// Function
// - keep bus parity, bus access and realtime parity flags at bits 31..29.
// - keep sequencer command, late, error, timeout and upload flags at 28..20.
// - expansion bus flags at bits 19, 18; two-wire flags at 17, 16.
// - audio protection 15..12, audio fifo 11, video 10, 9, field id 8, 7.
// - pin interrupt conditions on pins 3..0 set status bits 6..3.
// - bit 2 for counters 1,2,4,5, bit 1 counter 3, bit 0 counter 0.
// - four pins, each with an 8-bit field of the pin control register.
// - upper bits 00 make an input; bits 5:4 pick none, rise, fall, both.
// - upper bits 01 drive a constant level equal to field bit 4.
// - upper bits 11 output the live status bit addressed by bits 5:0.
// - six counters in two registers, one 12-bit and two 10-bit each.
// - each counter counts one of 64 sources chosen on its own.
// - a counter passing its threshold goes to zero and sets its flag.
// - counter register one shows counters two, one, zero at 31:22, 21:12, 11:0.
// - counter register two shows counters five, four, three likewise.
// - writing 1 to a status bit clears that flag.
// - an enable register, same positions, lets each flag raise the interrupt.
// - each counter has a 6-bit source, an enable and a write-one clear.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
module sgec_top import sgec_pkg::*; (
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic [11:0]         address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  input  wire logic [UNIT_W-1:0]   unit_event,
  input  wire logic [31:0]         secondary_status,
  input  wire logic [3:0]          gpio_in,
  output logic      [3:0]          gpio_out,
  output logic      [3:0]          gpio_oe,
  output logic                     irq_request
);
  typedef struct packed {
    sgec_bus_t        bus;
    logic [31:0]      rdata;
    logic [31:0]      enable;
    logic [31:0]      pin_ctrl;
    logic [31:0]      status;
    logic [1:0][23:0] sel;
    logic [1:0][31:0] thr;
    logic [5:0][11:0] cnt;
    logic [2:0]       hit;
    logic [3:0][2:0]  sync;
    logic [3:0]       level;
    logic [3:0]       pin_out;
    logic [3:0]       pin_oe;
    logic             irq;
  } sgec_state_t;

  sgec_state_t      s;
  sgec_state_t      next_s;
  logic             req;
  logic             accept;
  logic             wr;
  logic [31:0]      wmask;
  logic [31:0]      set_vec;
  logic [31:0]      clr_mask;
  logic [3:0]       pin_event;
  logic [3:0]       mon_bit;
  logic [63:0]      src;
  logic [5:0]       cnt_step;
  logic [5:0]       cnt_clr;
  logic [2:0]       hit_now;

  // width of counter i: slot 0 of each register is the wide one
  function automatic logic [11:0] cnt_max(input int i);
    cnt_max = (i % 3 == 0) ? 12'hfff : 12'h3ff;
  endfunction

  // lsb of counter i inside its counter or threshold register
  function automatic int slot_lsb(input int i);
    slot_lsb = (i % 3 == 0) ? 0 : ((i % 3 == 1) ? SLOT1_LSB : SLOT2_LSB);
  endfunction

  // counter register image
  function automatic logic [31:0] cnt_word(input logic [5:0][11:0] c, input int r);
    cnt_word = {c[3*r+2][CNT_NARROW-1:0], c[3*r+1][CNT_NARROW-1:0],
                c[3*r][CNT_WIDE-1:0]};
  endfunction

  // bus handshake: one wait cycle, then the answer
  assign req         = read | write;
  assign waitrequest = req && (s.bus != BUS_ANSWER);
  assign accept      = req && (s.bus == BUS_ANSWER);
  assign wr          = accept && write;
  assign wmask       = {{8{byteenable[3]}}, {8{byteenable[2]}},
                        {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign clr_mask    = (wr && address == OFS_STATUS) ? (writedata & wmask) : RST_WORD;

  // stable level that pin p takes at the next edge: the last two stages must agree
  function automatic logic gpio_level_new(input int p);
    gpio_level_new = (s.sync[p][1] == s.sync[p][2]) ? s.sync[p][2] : s.level[p];
  endfunction

  // live status bit selected by a 6-bit address
  function automatic logic src_live(input logic [5:0] a);
    src_live = (a[5]) ? secondary_status[a[4:0]] : s.status[a[4:0]];
  endfunction

  // threshold of counter i; the word is padded so slot 2 reads zeros past bit 31
  function automatic logic [11:0] thr_val(input int i);
    logic [43:0] w;
    w       = {12'h0, s.thr[i/3]};
    thr_val = w[slot_lsb(i) +: CNT_WIDE] & cnt_max(i);
  endfunction

  // pin interrupt conditions from the synchronised levels
  always_comb begin
    logic [PF_W-1:0] f;
    logic            rise;
    logic            fall;
    f         = '0;
    rise      = 1'b0;
    fall      = 1'b0;
    pin_event = 4'h0;
    mon_bit   = 4'h0;
    for (int p = 0; p < 4; p++) begin
      f    = s.pin_ctrl[p*PF_W +: PF_W];
      // old stable level against the one taken at this edge
      rise = gpio_level_new(p) & ~s.level[p];
      fall = ~gpio_level_new(p) & s.level[p];
      // reserved mode 10 never matches here
      if (f[PF_MODE +: 2] == MODE_IN) begin
        case (f[PF_EDGE +: 2])
          EDGE_RISE: pin_event[p] = rise;
          EDGE_FALL: pin_event[p] = fall;
          EDGE_BOTH: pin_event[p] = rise | fall;
          default:   pin_event[p] = 1'b0;
        endcase
      end
      mon_bit[p] = src_live(f[5:0]);
    end
  end

  // all flag set events of this cycle
  always_comb begin
    set_vec = RST_WORD;
    set_vec[31:UNIT_LSB]         = unit_event;
    set_vec[PIN_LSB +: 4]        = pin_event;
    set_vec[BIT_ECS:BIT_EC0]     = s.hit;
  end

  // counting sources: primary events, then secondary levels
  assign src = {secondary_status, set_vec};

  // per-counter step, clear and threshold hit
  always_comb begin
    logic [7:0]  slot;
    logic [12:0] nxt;
    logic [11:0] thr;
    slot     = '0;
    nxt      = '0;
    thr      = '0;
    cnt_step = 6'h0;
    cnt_clr  = 6'h0;
    hit_now  = 3'h0;
    for (int i = 0; i < 6; i++) begin
      slot        = s.sel[i/3][(i%3)*SEL_SLOT +: SEL_SLOT];
      cnt_step[i] = slot[SEL_EN] && src[slot[SEL_SRC +: 6]];
      cnt_clr[i]  = wr && byteenable[i%3] && writedata[(i%3)*SEL_SLOT + SEL_CLR]
                    && (address == ((i < 3) ? OFS_SEL1 : OFS_SEL2));
      thr         = thr_val(i);
      nxt         = {1'b0, s.cnt[i]} + 13'h1;
      if (cnt_step[i] && !cnt_clr[i] && nxt > {1'b0, thr}) begin
        if (i == 0) begin
          hit_now[BIT_EC0] = 1'b1;
        end else if (i == 3) begin
          hit_now[BIT_EC3] = 1'b1;
        end else begin
          hit_now[BIT_ECS] = 1'b1;
        end
      end
    end
  end

  // next state
  always_comb begin
    logic [12:0] nxt;
    nxt    = '0;
    next_s = s;
    // bus sequencing and read data
    case (s.bus)
      BUS_IDLE: begin
        if (req) begin
          next_s.bus = BUS_ANSWER;
        end
        case (address)
          OFS_ENABLE: next_s.rdata = s.enable;
          OFS_PIN:    next_s.rdata = s.pin_ctrl;
          OFS_SEL1:   next_s.rdata = {8'h0, s.sel[0] & 24'hfefefe};
          OFS_SEL2:   next_s.rdata = {8'h0, s.sel[1] & 24'hfefefe};
          OFS_STATUS: next_s.rdata = s.status;
          OFS_CNT1:   next_s.rdata = cnt_word(s.cnt, 0);
          OFS_CNT2:   next_s.rdata = cnt_word(s.cnt, 1);
          OFS_THR1:   next_s.rdata = s.thr[0];
          OFS_THR2:   next_s.rdata = s.thr[1];
          default:    next_s.rdata = RST_WORD;
        endcase
      end
      BUS_ANSWER: next_s.bus = BUS_IDLE;
      default:    next_s.bus = BUS_IDLE;
    endcase
    // software writes
    if (wr) begin
      case (address)
        OFS_ENABLE: next_s.enable   = (s.enable & ~wmask) | (writedata & wmask);
        OFS_PIN:    next_s.pin_ctrl = (s.pin_ctrl & ~wmask) | (writedata & wmask);
        OFS_SEL1:   next_s.sel[0]   = (s.sel[0] & ~wmask[23:0]) | (writedata[23:0] & wmask[23:0]);
        OFS_SEL2:   next_s.sel[1]   = (s.sel[1] & ~wmask[23:0]) | (writedata[23:0] & wmask[23:0]);
        OFS_THR1:   next_s.thr[0]   = (s.thr[0] & ~wmask) | (writedata & wmask);
        OFS_THR2:   next_s.thr[1]   = (s.thr[1] & ~wmask) | (writedata & wmask);
        default:    next_s.enable   = s.enable;
      endcase
    end
    // flags: a set in the same cycle beats the clear
    next_s.status = (s.status & ~clr_mask) | set_vec;
    next_s.hit    = hit_now;
    // counters
    for (int i = 0; i < 6; i++) begin
      nxt = {1'b0, s.cnt[i]} + 13'h1;
      if (cnt_clr[i]) begin
        next_s.cnt[i] = RST_CNT;
      end else if (cnt_step[i]) begin
        if (nxt > {1'b0, thr_val(i)}) begin
          next_s.cnt[i] = RST_CNT;
        end else begin
          next_s.cnt[i] = nxt[11:0] & cnt_max(i);
        end
      end
    end
    // pin synchronisers and outputs
    for (int p = 0; p < 4; p++) begin
      next_s.sync[p] = {s.sync[p][1:0], gpio_in[p]};
      if (s.sync[p][1] == s.sync[p][2]) begin
        next_s.level[p] = s.sync[p][2];
      end
      case (s.pin_ctrl[p*PF_W + PF_MODE +: 2])
        MODE_CONST: begin
          next_s.pin_oe[p]  = 1'b1;
          next_s.pin_out[p] = s.pin_ctrl[p*PF_W + PF_LEVEL];
        end
        MODE_MON: begin
          next_s.pin_oe[p]  = 1'b1;
          next_s.pin_out[p] = mon_bit[p];
        end
        default: begin
          next_s.pin_oe[p]  = 1'b0;
          next_s.pin_out[p] = 1'b0;
        end
      endcase
    end
    next_s.irq = |(s.status & s.enable);
  end

  // state register
  always_ff @(posedge clock) begin
    if (srst) begin
      s.bus      <= BUS_IDLE;
      s.rdata    <= RST_WORD;
      s.enable   <= RST_WORD;
      s.pin_ctrl <= RST_WORD;
      s.status   <= RST_WORD;
      s.sel      <= '0;
      s.thr      <= '0;
      s.cnt      <= '0;
      s.hit      <= 3'h0;
      s.sync     <= {4{RST_SYNC}};
      s.level    <= 4'h0;
      s.pin_out  <= 4'h0;
      s.pin_oe   <= 4'h0;
      s.irq      <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign readdata    = s.rdata;
  assign gpio_out    = s.pin_out;
  assign gpio_oe     = s.pin_oe;
  assign irq_request = s.irq;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  status_clear_a: assert property (wr && address == OFS_STATUS |=>
    ((s.status & $past(clr_mask) & ~$past(set_vec)) == 32'h0))
    else $error("status bit not cleared by write of one");
  unit_flags_a: assert property (unit_event != 0 |=>
    ((s.status[31:UNIT_LSB] & $past(unit_event)) == $past(unit_event)))
    else $error("unit event did not set its flag");
  pin_rise_a: assert property (pin_event[0] |=> s.status[PIN_LSB])
    else $error("pin condition did not set pin flag");
  pin_const_a: assert property (s.pin_ctrl[7:6] == MODE_CONST |=>
    gpio_oe[0] && gpio_out[0] == $past(s.pin_ctrl[PF_LEVEL]))
    else $error("constant pin level wrong");
  pin_monitor_a: assert property (s.pin_ctrl[7:6] == MODE_MON |=>
    gpio_oe[0] && gpio_out[0] == $past(mon_bit[0]))
    else $error("monitor pin does not follow status");
  reserved_quiet_a: assert property (s.pin_ctrl[7:6] == 2'h2 |->
    !pin_event[0] ##1 !gpio_oe[0])
    else $error("reserved pin mode active");
  counter_wrap_a: assert property (hit_now[BIT_EC0] |=>
    s.cnt[0] == 12'h0 ##1 s.status[BIT_EC0])
    else $error("counter zero did not wrap and flag");
  counter_step_a: assert property (cnt_step[0] && !cnt_clr[0] && !hit_now[BIT_EC0] |=>
    s.cnt[0] == $past(s.cnt[0]) + 12'h1)
    else $error("counter zero missed a count");
  counter_clear_a: assert property (cnt_clr[4] |=> s.cnt[4] == 12'h0)
    else $error("counter four not cleared");
  irq_enable_a: assert property (|(s.status & s.enable) |=> irq_request)
    else $error("enabled flag raised no interrupt");
  sync_agree_a: assert property ($changed(s.level[1]) |->
    $past(s.sync[1][1]) == $past(s.sync[1][2]))
    else $error("pin level taken before stages agree");
  cnt_read_a: assert property (req && s.bus == BUS_IDLE && address == OFS_CNT1 |=>
    readdata[11:0] == $past(s.cnt[0]) && !waitrequest)
    else $error("counter register one read wrong");
  cnt2_read_a: assert property (req && s.bus == BUS_IDLE && address == OFS_CNT2 |=>
    readdata == {$past(s.cnt[5][9:0]), $past(s.cnt[4][9:0]), $past(s.cnt[3])})
    else $error("counter register two read wrong");
  pin_fall_a: assert property (s.pin_ctrl[7:4] == 4'h2 && s.level[0] && !next_s.level[0] |=>
    s.status[PIN_LSB])
    else $error("falling pin edge did not set pin flag");
  one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered after one wait");
  input_release_a: assert property (s.pin_ctrl[7:6] == MODE_IN |=> !gpio_oe[0])
    else $error("input pin is driven");

  read_cover_c:  cover property (read && !waitrequest);
  wrap_cover_c:  cover property (hit_now[BIT_ECS]);
  pin_cover_c:   cover property (pin_event[2]);
  clash_cover_c: cover property ((clr_mask & set_vec) != 32'h0);
endmodule

//--- bench/sgec_pin_partner.sv
// sgec_pin_partner: outside devices on the four general pins.
// assumes the bench sets drive_level; the pins have no pull resistor.
`timescale 1ns/1ns
module sgec_pin_partner (
  input  wire logic [3:0] drive_level,
  input  wire logic [3:0] gpio_out,
  input  wire logic [3:0] gpio_oe,
  output logic      [3:0] pin_wire,
  output logic      [3:0] gpio_in
);
  // a pin carries the device level while it drives, else the outside level
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pin_wire[p] = gpio_oe[p] ? gpio_out[p] : drive_level[p];
    end
    gpio_in = pin_wire;
  end
endmodule

//--- bench/status_gpio_event_counter_tb.sv
// status_gpio_event_counter_tb: registers, pins and counters of sgec_top.
// assumes an avalon port with waitrequest and a 100 MHz clock.
`timescale 1ns/1ns
module status_gpio_event_counter_tb import sgec_pkg::*;;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} sgec_row_t;
  localparam logic [11:0] REGS [9] = '{OFS_ENABLE, OFS_PIN, OFS_SEL1, OFS_SEL2, OFS_STATUS,
                                       OFS_CNT1, OFS_CNT2, OFS_THR1, OFS_THR2};
  localparam sgec_row_t ROWS [7] = '{'{OFS_ENABLE, 32'hffffffff, 32'hffffffff},
    '{OFS_PIN, 32'h23100130, 32'h23100130}, '{OFS_SEL1, 32'h00fdfdfd, 32'h00fcfcfc},
    '{OFS_SEL2, 32'h00fdfdfd, 32'h00fcfcfc}, '{OFS_CNT1, 32'hffffffff, 32'h0},
    '{OFS_CNT2, 32'hffffffff, 32'h0}, '{12'h100, 32'hffffffff, 32'h0}};
  localparam logic [7:0] PMODE [5] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h80};
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] address = 12'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [24:0] unit_event = 25'h0;
  logic [31:0] secondary_status = 32'h0;
  logic [3:0]  drive_level = 4'h0;
  logic [3:0]  gpio_in;
  logic [3:0]  gpio_out;
  logic [3:0]  gpio_oe;
  logic [3:0]  pin_wire;
  logic        irq_request;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // clock and cycle ceiling
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  sgec_top u_dut (.clock(clock), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .unit_event(unit_event), .secondary_status(secondary_status),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq_request(irq_request));
  sgec_pin_partner u_pins (.drive_level(drive_level), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pin_wire(pin_wire), .gpio_in(gpio_in));

  // comparisons
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pins(input string what, input logic [3:0] exp, input logic [3:0] got);
    chk_word(what, {28'h0, exp}, {28'h0, got});
  endtask

  // one avalon transfer: raised after an edge, held until the edge that sees waitrequest low
  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 32'h0, q);
    chk_word(what, exp, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] s;
    cyc(16);
    srst <= 1'b0;
    cyc(2);
    foreach (REGS[i]) rd("reset value", REGS[i], 32'h0);
    @(negedge clock);
    chk_pins("reset oe", 4'h0, gpio_oe);
    chk_pins("reset irq", 4'h0, {3'h0, irq_request});
    @(posedge clock);
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rd($sformatf("row %0d", i), ROWS[i].a, ROWS[i].e);
    end
    // byte lanes: only lane 1 of the enable register is written
    byteenable <= 4'h2;
    wr(OFS_ENABLE, 32'h0);
    byteenable <= 4'hf;
    rd("byte lanes", OFS_ENABLE, 32'hffff00ff);
    wr(OFS_ENABLE, 32'hffffffff);
    $display("test registers done");
    // every unit flag sets, interrupts and clears by writing one
    for (int k = 0; k < UNIT_W; k++) begin
      unit_event <= 25'h1 << k;
      @(posedge clock);
      unit_event <= 25'h0;
      cyc(2);
      rd("status set", OFS_STATUS, 32'h1 << (k + 7));
      chk_pins("irq set", 4'h1, {3'h0, irq_request});
      wr(OFS_STATUS, 32'h1 << (k + 7));
      rd("status clear", OFS_STATUS, 32'h0);
      chk_pins("irq clear", 4'h0, {3'h0, irq_request});
    end
    $display("test status done");
    // input edge modes, pins 0 and 1 toggled
    foreach (PMODE[m]) begin
      wr(OFS_PIN, {4{PMODE[m]}});
      drive_level <= 4'h0;
      cyc(8);
      wr(OFS_STATUS, 32'hffffffff);
      drive_level <= 4'h3;
      cyc(8);
      rd("pin rise", OFS_STATUS, (m == 1 || m == 3) ? 32'h18 : 32'h0);
      chk_pins("input oe", 4'h0, gpio_oe);
      wr(OFS_STATUS, 32'hffffffff);
      drive_level <= 4'h0;
      cyc(8);
      rd("pin fall", OFS_STATUS, (m == 2 || m == 3) ? 32'h18 : 32'h0);
    end
    $display("test pin inputs done");
    // constant outputs, bit 5 and low nibble ignored
    drive_level <= 4'h5;
    wr(OFS_PIN, 32'h506f7f40);
    @(negedge clock);
    chk_pins("const oe", 4'hf, gpio_oe);
    chk_pins("const level", 4'ha, pin_wire);
    @(posedge clock);
    // monitor status bit 7 on pin 0 and secondary bit 5 on pin 1
    drive_level <= 4'h0;
    secondary_status <= 32'h20;
    wr(OFS_PIN, 32'h0000e5c7);
    unit_event <= 25'h1;
    @(posedge clock);
    unit_event <= 25'h0;
    cyc(2);
    @(negedge clock);
    chk_pins("monitor oe", 4'h3, gpio_oe);
    chk_pins("monitor on", 4'h3, gpio_out & 4'h3);
    @(posedge clock);
    wr(OFS_STATUS, 32'hffffffff);
    @(negedge clock);
    chk_pins("monitor off", 4'h2, gpio_out & 4'h3);
    @(posedge clock);
    secondary_status <= 32'h0;
    $display("test pin outputs done");
    // counter c counts secondary bit c for c+2 cycles
    wr(OFS_THR1, 32'hffffffff);
    wr(OFS_THR2, 32'hffffffff);
    wr(OFS_SEL1, 32'h008a8682);
    wr(OFS_SEL2, 32'h0096928e);
    for (int i = 0; i < 7; i++) begin
      s = 32'h0;
      for (int c = 0; c < 6; c++) s[c] = (c + 2 > i);
      secondary_status <= s;
      @(posedge clock);
    end
    secondary_status <= 32'h0;
    cyc(2);
    rd("counts one", OFS_CNT1, {10'd4, 10'd3, 12'd2});
    rd("counts two", OFS_CNT2, {10'd7, 10'd6, 12'd5});
    wr(OFS_THR1, {10'd4, 10'd3, 12'd2});
    wr(OFS_THR2, {10'd7, 10'd6, 12'd5});
    rd("equal no flag", OFS_STATUS, 32'h0);
    // one more count on counters 3, 1, 0 in turn passes each threshold
    for (int j = 0; j < 3; j++) begin
      secondary_status <= 32'h1 << ((j == 0) ? 3 : (j == 1) ? 1 : 0);
      @(posedge clock);
      secondary_status <= 32'h0;
      cyc(2);
      rd("threshold flag", OFS_STATUS, (j == 0) ? 32'h2 : (j == 1) ? 32'h6 : 32'h7);
    end
    rd("wrap one", OFS_CNT1, {10'd4, 10'd0, 12'd0});
    rd("wrap two", OFS_CNT2, {10'd7, 10'd6, 12'd0});
    wr(OFS_SEL1, 32'h008b8783);
    rd("clear one", OFS_CNT1, 32'h0);
    rd("keep two", OFS_CNT2, {10'd7, 10'd6, 12'd0});
    $display("test counters done");
    // reset in mid-run: counters, pin drive and interrupt return to rest
    srst <= 1'b1;
    cyc(4);
    srst <= 1'b0;
    cyc(2);
    chk_pins("mid reset oe", 4'h0, gpio_oe);
    rd("mid reset counts", OFS_CNT2, 32'h0);
    chk_pins("mid reset irq", 4'h0, {3'h0, irq_request});
    $display("test reset done");
    give_verdict();
  end
endmodule
